// ==== spvl_pkg.sv ====
// Package for the cascaded position/velocity servo regulator.
// Assumes a single 125 MHz clock and an APB register port.
package spvl_pkg;

  localparam int DATA_W     = 32;
  localparam int GAIN_W     = 16;
  localparam int ACC_W      = 50;
  localparam int GAIN_SHIFT = 8;
  localparam int ADDR_W     = 8;

  // Servo sample period and the clock that counts it
  localparam int CLK_PERIOD_NS   = 8;
  localparam int SERVO_PERIOD_NS = 62500;
  localparam int SERVO_TICK_CYCLES = SERVO_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TUNE_TICKS        = 64;

  localparam logic [ADDR_W-1:0] ADDR_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_POS_PROP   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_POS_INT    = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_VEL_LEAD   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ACCEL_LEAD = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_VEL_PROP   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_VEL_INT    = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_WINDOW     = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_TUNE_STEP  = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_TRACK_ERR  = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_VEL_CMD    = 8'h2c;
  localparam logic [ADDR_W-1:0] ADDR_TORQUE     = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_SPEED      = 8'h34;

  localparam int CTRL_FB_EXT = 0;
  localparam int CTRL_MANUAL = 1;
  localparam int CTRL_AUTO   = 2;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_INWIN  = 2;

  localparam logic [GAIN_W-1:0] RST_POS_PROP   = 16'h0100;
  localparam logic [GAIN_W-1:0] RST_VEL_PROP   = 16'h0100;
  localparam logic [GAIN_W-1:0] RST_ZERO_GAIN  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_WINDOW     = 32'h0000_0010;
  localparam logic [DATA_W-1:0] RST_TUNE_STEP  = 32'h0000_0004;
  // Gain set loaded by the automatic tuner
  localparam logic [GAIN_W-1:0] AUTO_POS_PROP   = 16'h0080;
  localparam logic [GAIN_W-1:0] AUTO_POS_INT    = 16'h0004;
  localparam logic [GAIN_W-1:0] AUTO_VEL_LEAD   = 16'h0100;
  localparam logic [GAIN_W-1:0] AUTO_ACCEL_LEAD = 16'h0010;
  localparam logic [GAIN_W-1:0] AUTO_VEL_PROP   = 16'h0200;
  localparam logic [GAIN_W-1:0] AUTO_VEL_INT    = 16'h0008;

  typedef enum logic [1:0] {TUNE_IDLE, TUNE_RUN, TUNE_LOAD} spvl_tune_type;

  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [ADDR_W-1:0]       paddr;
    logic [DATA_W-1:0]       pwdata;
  } spvl_apb_req_type;

  typedef struct packed {
    logic signed [DATA_W-1:0] profile;
    logic signed [DATA_W-1:0] jog;
    logic signed [DATA_W-1:0] gear;
    logic signed [DATA_W-1:0] cam;
  } spvl_cmd_type;

  typedef struct packed {
    logic [GAIN_W-1:0] pos_prop;
    logic [GAIN_W-1:0] pos_int;
    logic [GAIN_W-1:0] vel_lead;
    logic [GAIN_W-1:0] accel_lead;
    logic [GAIN_W-1:0] vel_prop;
    logic [GAIN_W-1:0] vel_int;
  } spvl_gain_type;

  typedef struct packed {
    logic                     fb_ext;
    logic                     manual_tune;
    spvl_gain_type            gain;
    logic signed [DATA_W-1:0] window;
    logic signed [DATA_W-1:0] tune_step;
    logic [DATA_W-1:0]        tick_cnt;
    logic                     tick;
    spvl_tune_type            tune;
    logic [DATA_W-1:0]        tune_cnt;
    logic                     tune_done;
    logic                     in_window;
    logic signed [DATA_W-1:0] prev_cmd;
    logic signed [DATA_W-1:0] prev_cmd_vel;
    logic signed [DATA_W-1:0] prev_motor;
    logic signed [DATA_W-1:0] pos_integ;
    logic signed [DATA_W-1:0] vel_integ;
    logic signed [DATA_W-1:0] track_err;
    logic signed [DATA_W-1:0] speed;
    logic signed [DATA_W-1:0] vel_cmd;
    logic signed [DATA_W-1:0] torque;
    logic [DATA_W-1:0]        prdata;
  } spvl_state_type;

endpackage

// ==== spvl_servo_loop.sv ====
// Cascaded position PI loop with feedforward and inner velocity PI loop.
// Assumes command sources and encoder counts come from logic on ref_clk;
// software reaches the registers over a zero-wait APB slave.
//
// Summary of operation
// RL1 - Total position command is profile plus jog plus gear plus cam.
// RL2 - Tracking error is command minus selected feedback, each servo tick.
// RL3 - Velocity feedback always comes from the motor encoder.
// RL4 - Position feedback is motor or external encoder, chosen by config bit.
// RL5 - Measured speed is the motor count change per tick.
// RL6 - Proportional term is position gain times tracking error.
// RL7 - Command is differentiated to feed both feedforward paths.
// RL8 - Velocity lead is gain times command derivative; zero if unchanged.
// RL9 - Acceleration lead is gain times second derivative of command.
// RL10 - Position integrator accumulates only inside the integrator window.
// RL11 - Velocity command is sum of proportional, integral and lead terms.
// RL12 - Velocity error times gains gives torque command to amplifier.
// RL13 - Velocity loop is PI; integral gain may be zero.
// RL14 - Manual tune adds a step to the command; gains stay writable.
// RL15 - Automatic tuning sets velocity and position loop gains.
// RL16 - Software should keep velocity lead at or below full scale.
// RL17 - Software should keep position bandwidth below a third of velocity.
// RL18 - Regulators run once per tick, saturating signed fixed point.
// RL19 - Outside the window the position integrator holds its value.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module spvl_servo_loop
  import spvl_pkg::*;
#(
  parameter int TICK_CYCLES = SERVO_TICK_CYCLES
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire spvl_apb_req_type         apb_req,
  output logic [DATA_W-1:0]             prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire spvl_cmd_type             motion_cmd,
  input  wire logic signed [DATA_W-1:0] motor_count,
  input  wire logic signed [DATA_W-1:0] ext_count,
  output logic signed [DATA_W-1:0]      torque_command
);

  localparam logic signed [ACC_W-1:0] SAT_MAX =
    ACC_W'(signed'({1'b0, {(DATA_W-1){1'b1}}}));
  localparam logic signed [ACC_W-1:0] SAT_MIN = -SAT_MAX - ACC_W'(1);

  function automatic logic signed [DATA_W-1:0] sat(
    input logic signed [ACC_W-1:0] x);
    if (x > SAT_MAX) begin
      return SAT_MAX[DATA_W-1:0];
    end else if (x < SAT_MIN) begin
      return SAT_MIN[DATA_W-1:0];
    end
    return x[DATA_W-1:0];
  endfunction

  function automatic logic signed [ACC_W-1:0] wide(
    input logic signed [DATA_W-1:0] x);
    return ACC_W'(x);
  endfunction

  function automatic logic signed [ACC_W-1:0] gmul(
    input logic [GAIN_W-1:0]        g,
    input logic signed [DATA_W-1:0] x);
    logic signed [ACC_W-1:0] p;
    p = ACC_W'(signed'({1'b0, g})) * wide(x);
    return p >>> GAIN_SHIFT;
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'b00 && a <= ADDR_SPEED;
  endfunction

  // Whole module state in one record
  spvl_state_type st;
  spvl_state_type next_st;

  logic signed [DATA_W-1:0] cmd_base;
  logic signed [DATA_W-1:0] cmd_total;
  logic signed [DATA_W-1:0] pos_fb;
  logic signed [DATA_W-1:0] err_now;
  logic signed [DATA_W-1:0] cmd_vel;
  logic signed [DATA_W-1:0] cmd_acc;
  logic signed [DATA_W-1:0] speed_now;
  logic signed [DATA_W-1:0] err_abs;
  logic                     win_now;
  logic signed [DATA_W-1:0] integ_now;
  logic signed [ACC_W-1:0]  lead_term;
  logic signed [DATA_W-1:0] vcmd_now;
  logic signed [DATA_W-1:0] verr_now;
  logic signed [DATA_W-1:0] vinteg_now;
  logic signed [DATA_W-1:0] torque_now;
  logic                     wr_en;
  logic                     setup;
  logic                     step_on;

  // Command summing and manual or automatic step injection
  assign cmd_base = sat(wide(motion_cmd.profile) + wide(motion_cmd.jog)
                      + wide(motion_cmd.gear) + wide(motion_cmd.cam)); // RL1
  assign step_on  = st.manual_tune || st.tune == TUNE_RUN;
  assign cmd_total = step_on ? sat(wide(cmd_base) + wide(st.tune_step))
                             : cmd_base; // RL14

  // Outer position loop
  assign pos_fb   = st.fb_ext ? ext_count : motor_count; // RL4
  assign err_now  = sat(wide(cmd_total) - wide(pos_fb)); // RL2
  assign cmd_vel  = sat(wide(cmd_total) - wide(st.prev_cmd)); // RL7
  assign cmd_acc  = sat(wide(cmd_vel) - wide(st.prev_cmd_vel)); // RL9
  assign speed_now = sat(wide(motor_count) - wide(st.prev_motor)); // RL3 RL5
  assign err_abs  = err_now < 0 ? sat(-wide(err_now)) : err_now;
  assign win_now  = err_abs <= st.window;
  assign integ_now = win_now ? sat(wide(st.pos_integ) + wide(err_now))
                             : st.pos_integ; // RL10 RL19
  assign lead_term = gmul(st.gain.vel_lead, cmd_vel)
                   + gmul(st.gain.accel_lead, cmd_acc); // RL8 RL9
  assign vcmd_now = sat(gmul(st.gain.pos_prop, err_now)
                      + gmul(st.gain.pos_int, integ_now)
                      + lead_term); // RL6 RL11

  // Inner velocity loop
  assign verr_now   = sat(wide(vcmd_now) - wide(speed_now)); // RL12
  assign vinteg_now = st.gain.vel_int == RST_ZERO_GAIN ? '0
                    : sat(wide(st.vel_integ) + wide(verr_now)); // RL13
  assign torque_now = sat(gmul(st.gain.vel_prop, verr_now)
                        + gmul(st.gain.vel_int, vinteg_now)); // RL12 RL13

  // APB slave, zero wait states
  assign setup   = apb_req.psel && !apb_req.penable;
  assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite
                && addr_ok(apb_req.paddr);
  assign pready  = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable
                && !addr_ok(apb_req.paddr);
  assign prdata  = st.prdata;
  assign torque_command = st.torque;

  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    // Sample tick divider
    if (st.tick_cnt == DATA_W'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + DATA_W'(1);
    end
    // One regulator update per tick
    if (st.tick) begin
      next_st.prev_cmd     = cmd_total; // RL18
      next_st.prev_cmd_vel = cmd_vel;
      next_st.prev_motor   = motor_count;
      next_st.track_err    = err_now;
      next_st.in_window    = win_now;
      next_st.pos_integ    = integ_now; // RL19
      next_st.speed        = speed_now;
      next_st.vel_cmd      = vcmd_now;
      next_st.vel_integ    = vinteg_now;
      next_st.torque       = torque_now; // RL18
    end
    // Automatic tuner: step for a fixed span then load its gain set
    case (st.tune)
      TUNE_RUN: begin
        if (st.tick) begin
          if (st.tune_cnt == DATA_W'(TUNE_TICKS - 1)) begin
            next_st.tune = TUNE_LOAD;
          end else begin
            next_st.tune_cnt = st.tune_cnt + DATA_W'(1);
          end
        end
      end
      TUNE_LOAD: begin
        next_st.gain.pos_prop   = AUTO_POS_PROP; // RL15
        next_st.gain.pos_int    = AUTO_POS_INT;
        next_st.gain.vel_lead   = AUTO_VEL_LEAD;
        next_st.gain.accel_lead = AUTO_ACCEL_LEAD;
        next_st.gain.vel_prop   = AUTO_VEL_PROP;
        next_st.gain.vel_int    = AUTO_VEL_INT;
        next_st.tune            = TUNE_IDLE;
      end
      default: begin
        next_st.tune_cnt = '0;
      end
    endcase
    // Register writes; gains stay writable while stepping
    if (wr_en) begin
      if (apb_req.paddr == ADDR_CTRL) begin
        next_st.fb_ext      = apb_req.pwdata[CTRL_FB_EXT];
        next_st.manual_tune = apb_req.pwdata[CTRL_MANUAL]; // RL14
        if (apb_req.pwdata[CTRL_AUTO] && st.tune == TUNE_IDLE) begin
          next_st.tune     = TUNE_RUN;
          next_st.tune_cnt = '0;
        end
      end else if (apb_req.paddr == ADDR_STATUS) begin
        if (apb_req.pwdata[STAT_DONE]) begin
          next_st.tune_done = 1'b0;
        end
      end else if (apb_req.paddr == ADDR_POS_PROP) begin
        next_st.gain.pos_prop = apb_req.pwdata[GAIN_W-1:0];
      end else if (apb_req.paddr == ADDR_POS_INT) begin
        next_st.gain.pos_int = apb_req.pwdata[GAIN_W-1:0];
      end else if (apb_req.paddr == ADDR_VEL_LEAD) begin
        next_st.gain.vel_lead = apb_req.pwdata[GAIN_W-1:0];
      end else if (apb_req.paddr == ADDR_ACCEL_LEAD) begin
        next_st.gain.accel_lead = apb_req.pwdata[GAIN_W-1:0];
      end else if (apb_req.paddr == ADDR_VEL_PROP) begin
        next_st.gain.vel_prop = apb_req.pwdata[GAIN_W-1:0];
      end else if (apb_req.paddr == ADDR_VEL_INT) begin
        next_st.gain.vel_int = apb_req.pwdata[GAIN_W-1:0];
      end else if (apb_req.paddr == ADDR_WINDOW) begin
        next_st.window = apb_req.pwdata;
      end else if (apb_req.paddr == ADDR_TUNE_STEP) begin
        next_st.tune_step = apb_req.pwdata;
      end
    end
    // Done flag: hardware set wins over software clear
    if (st.tune == TUNE_LOAD) begin
      next_st.tune_done = 1'b1;
    end
    // Read data captured in the setup phase
    if (setup) begin
      next_st.prdata = '0;
      if (apb_req.paddr == ADDR_CTRL) begin
        next_st.prdata[CTRL_FB_EXT] = st.fb_ext;
        next_st.prdata[CTRL_MANUAL] = st.manual_tune;
      end else if (apb_req.paddr == ADDR_STATUS) begin
        next_st.prdata[STAT_BUSY]  = st.tune != TUNE_IDLE;
        next_st.prdata[STAT_DONE]  = st.tune_done;
        next_st.prdata[STAT_INWIN] = st.in_window;
      end else if (apb_req.paddr == ADDR_POS_PROP) begin
        next_st.prdata[GAIN_W-1:0] = st.gain.pos_prop;
      end else if (apb_req.paddr == ADDR_POS_INT) begin
        next_st.prdata[GAIN_W-1:0] = st.gain.pos_int;
      end else if (apb_req.paddr == ADDR_VEL_LEAD) begin
        next_st.prdata[GAIN_W-1:0] = st.gain.vel_lead;
      end else if (apb_req.paddr == ADDR_ACCEL_LEAD) begin
        next_st.prdata[GAIN_W-1:0] = st.gain.accel_lead;
      end else if (apb_req.paddr == ADDR_VEL_PROP) begin
        next_st.prdata[GAIN_W-1:0] = st.gain.vel_prop;
      end else if (apb_req.paddr == ADDR_VEL_INT) begin
        next_st.prdata[GAIN_W-1:0] = st.gain.vel_int;
      end else if (apb_req.paddr == ADDR_WINDOW) begin
        next_st.prdata = st.window;
      end else if (apb_req.paddr == ADDR_TUNE_STEP) begin
        next_st.prdata = st.tune_step;
      end else if (apb_req.paddr == ADDR_TRACK_ERR) begin
        next_st.prdata = st.track_err;
      end else if (apb_req.paddr == ADDR_VEL_CMD) begin
        next_st.prdata = st.vel_cmd;
      end else if (apb_req.paddr == ADDR_TORQUE) begin
        next_st.prdata = st.torque;
      end else if (apb_req.paddr == ADDR_SPEED) begin
        next_st.prdata = st.speed;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st                 <= '0;
      st.gain.pos_prop   <= RST_POS_PROP;
      st.gain.vel_prop   <= RST_VEL_PROP;
      st.window          <= RST_WINDOW;
      st.tune_step       <= RST_TUNE_STEP;
      st.tune            <= TUNE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  a_cmd_sum_step: assert property (@(posedge ref_clk) disable iff (reset) // RL1
    !step_on |-> cmd_total == sat(wide(motion_cmd.profile)
      + wide(motion_cmd.jog) + wide(motion_cmd.gear) + wide(motion_cmd.cam)))
    else $error("total command not the sum of sources");

  a_err_feedback: assert property (@(posedge ref_clk) disable iff (reset) // RL2
    st.tick |=> st.track_err == sat(wide($past(cmd_total))
      - wide($past(st.fb_ext) ? $past(ext_count) : $past(motor_count))))
    else $error("tracking error uses wrong feedback");

  a_speed_motor: assert property (@(posedge ref_clk) disable iff (reset) // RL5
    st.tick |=> st.prev_motor == $past(motor_count))
    else $error("motor count not kept for speed");

  a_speed_count: assert property (@(posedge ref_clk) disable iff (reset) // RL3
    st.tick |=> st.speed == sat(wide($past(motor_count))
      - wide($past(st.prev_motor))))
    else $error("speed not from motor encoder");

  a_lead_zero: assert property (@(posedge ref_clk) disable iff (reset) // RL8
    cmd_total == st.prev_cmd |-> gmul(st.gain.vel_lead, cmd_vel) == 0)
    else $error("velocity lead nonzero on still command");

  a_integ_hold: assert property (@(posedge ref_clk) disable iff (reset) // RL19
    st.tick && !win_now |=> $stable(st.pos_integ))
    else $error("integrator moved outside window");

  a_vcmd_sum: assert property (@(posedge ref_clk) disable iff (reset) // RL11
    st.tick |=> st.vel_cmd == $past(vcmd_now) && st.torque == $past(torque_now))
    else $error("loop outputs not taken at tick");

  a_hold_between: assert property (@(posedge ref_clk) disable iff (reset) // RL18
    !st.tick |=> $stable(st.torque) && $stable(st.vel_cmd))
    else $error("regulator output changed between ticks");

  a_auto_gains: assert property (@(posedge ref_clk) disable iff (reset) // RL15
    st.tune == TUNE_LOAD && !wr_en |=> st.gain.vel_prop == AUTO_VEL_PROP
      && st.gain.pos_prop == AUTO_POS_PROP && st.tune_done)
    else $error("autotune gains not loaded");

  a_manual_step: assert property (@(posedge ref_clk) disable iff (reset) // RL14
    st.manual_tune |-> cmd_total == sat(wide(cmd_base) + wide(st.tune_step)))
    else $error("manual tune step missing");

  // Integrator, history, tick and tuner checks
  a_integ_gate: assert property (@(posedge ref_clk) disable iff (reset) // RL10
    st.tick && win_now |=> st.pos_integ
      == sat(wide($past(st.pos_integ)) + wide($past(err_now))))
    else $error("integrator skipped error in window");

  a_vint_clear: assert property (@(posedge ref_clk) disable iff (reset) // RL13
    st.tick && st.gain.vel_int == RST_ZERO_GAIN
      |=> st.vel_integ == 0)
    else $error("velocity integrator kept at zero gain");

  a_tick_pulse: assert property (@(posedge ref_clk) disable iff (reset) // RL18
    st.tick |=> !st.tick)
    else $error("sample tick longer than a cycle");

  a_ff_history: assert property (@(posedge ref_clk) disable iff (reset) // RL7
    st.tick |=> st.prev_cmd == $past(cmd_total)
      && st.prev_cmd_vel == $past(cmd_vel))
    else $error("command history not taken at tick");

  a_tune_done: assert property (@(posedge ref_clk) disable iff (reset) // RL15
    st.tune == TUNE_LOAD
      |=> st.tune_done && st.tune == TUNE_IDLE)
    else $error("tuner did not finish after load");

endmodule // spvl_servo_loop

`default_nettype wire

// ==== spvl_motor_model.sv ====
// Amplifier and encoder model at the far side of the servo loop.
// Assumes ref_clk domain; slow mode moves the motor every other clock.
`timescale 1ns/100ps
`default_nettype none
module spvl_motor_model
  import spvl_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire logic                     load,
  input  wire logic                     slow,
  input  wire logic signed [DATA_W-1:0] motor_set,
  input  wire logic signed [DATA_W-1:0] ext_set,
  input  wire logic signed [DATA_W-1:0] motor_rate,
  input  wire logic signed [DATA_W-1:0] torque_command,
  output logic signed [DATA_W-1:0]      motor_count,
  output logic signed [DATA_W-1:0]      ext_count,
  output logic signed [DATA_W-1:0]      applied_torque
);
  logic phase;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      motor_count <= '0;
      ext_count   <= '0;
      phase       <= 1'b0;
    end else begin
      phase <= ~phase;
      if (load) begin
        motor_count <= motor_set;
        ext_count   <= ext_set;
      end else if (!slow) begin
        motor_count <= motor_count + motor_rate;
      end else if (phase) begin
        motor_count <= motor_count + 2 * motor_rate;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    applied_torque <= torque_command;
  end
endmodule // spvl_motor_model
`default_nettype wire

// ==== servo_position_velocity_loop_tb.sv ====
// Self-checking bench for the cascaded servo regulator.
// Assumes spvl_pkg, spvl_servo_loop and spvl_motor_model.
`timescale 1ns/100ps
`default_nettype none
module servo_position_velocity_loop_tb
  import spvl_pkg::*;
;
  localparam int TC = 8;
  logic                     ref_clk, reset, pready, pslverr;
  spvl_apb_req_type         req;
  spvl_cmd_type             mc, mc_dut;
  logic [DATA_W-1:0]        prdata, q, a, b;
  logic signed [DATA_W-1:0] motor_count, ext_count, torque_command;
  logic signed [DATA_W-1:0] applied_torque, motor_set, ext_set;
  logic signed [DATA_W-1:0] motor_rate, ramp_r, ramp_a, ramp_p, e, vc;
  logic signed [DATA_W-1:0] v [6];
  logic                     err, load, slow, ramp_on, fx;
  logic [15:0]              kp, kvp;
  int                       n_fail, num_checks, j;
  int                       cycles = 0;

  spvl_servo_loop #(.TICK_CYCLES(TC)) spvl_servo_loop_inst (
    .ref_clk(ref_clk), .reset(reset), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motion_cmd(mc_dut),
    .motor_count(motor_count), .ext_count(ext_count),
    .torque_command(torque_command));
  spvl_motor_model spvl_motor_model_inst (
    .ref_clk(ref_clk), .reset(reset), .load(load), .slow(slow),
    .motor_set(motor_set), .ext_set(ext_set), .motor_rate(motor_rate),
    .torque_command(torque_command), .motor_count(motor_count),
    .ext_count(ext_count), .applied_torque(applied_torque));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end
  // Quadratic command ramp added on the profile source
  assign mc_dut = {mc.profile + ramp_p, mc.jog, mc.gear, mc.cam};
  always @(posedge ref_clk) begin
    if (ramp_on) begin
      ramp_p <= ramp_p + ramp_r;
      ramp_r <= ramp_r + ramp_a;
    end else begin
      ramp_p <= '0;
      ramp_r <= 32'sd5;
    end
  end

  function automatic logic signed [31:0] sat(input logic signed [63:0] x);
    if (x > 64'sh7fffffff) return 32'sh7fffffff;
    if (x < -64'sh80000000) return 32'sh80000000;
    return x[31:0];
  endfunction
  function automatic logic signed [31:0] mul(input logic [15:0] g,
                                             input logic signed [31:0] x);
    logic signed [63:0] p;
    p = $signed({48'h0, g}) * 64'(x);
    return sat(p >>> 8);
  endfunction

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    num_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, wr, ad, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, q, err);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] r);
    apb(1'b0, ad, '0, r, err);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] ex);
    rd(ad, q);
    chk(q, ex);
  endtask
  task automatic tick(input int n);
    repeat (n * TC) @(posedge ref_clk);
  endtask
  task automatic set_cmd(input logic signed [31:0] p, jg, gr, cm);
    @(posedge ref_clk);
    mc <= '{p, jg, gr, cm};
  endtask
  task automatic set_fb(input logic signed [31:0] m, x);
    @(posedge ref_clk);
    motor_set <= m;
    ext_set   <= x;
    load      <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
  endtask

  initial begin
    req = '0;
    mc = '0;
    {load, slow, ramp_on, fx} = '0;
    {motor_set, ext_set, motor_rate, ramp_a} = '0;
    {n_fail, num_checks} = '0;
    reset = 1'b1;
    void'($urandom(32'h25205f4e));
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rdc(ADDR_CTRL, 32'h0);
    rdc(ADDR_POS_PROP, 32'(RST_POS_PROP));
    rdc(ADDR_POS_INT, 32'h0);
    rdc(ADDR_VEL_LEAD, 32'h0);
    rdc(ADDR_ACCEL_LEAD, 32'h0);
    rdc(ADDR_VEL_PROP, 32'(RST_VEL_PROP));
    rdc(ADDR_VEL_INT, 32'h0);
    rdc(ADDR_WINDOW, RST_WINDOW);
    rdc(ADDR_TUNE_STEP, RST_TUNE_STEP);
    apb(1'b0, 8'h38, '0, q, err);
    chk(32'(err), 32'h1);
    chk(q, 32'h0);
    apb(1'b1, 8'h02, 32'h5, q, err);
    chk(32'(err), 32'h1);
    wr(ADDR_TORQUE, 32'h1234);
    rdc(ADDR_TORQUE, 32'h0);
    // Integrator: outside, on the edge of, then outside the window
    wr(ADDR_POS_PROP, 32'h0);
    wr(ADDR_POS_INT, 32'h100);
    set_cmd(32'sh20, 0, 0, 0);
    tick(4);
    rdc(ADDR_VEL_CMD, 32'h0);
    set_cmd(32'sh10, 0, 0, 0);
    tick(4);
    rd(ADDR_VEL_CMD, a);
    tick(2);
    rd(ADDR_VEL_CMD, b);
    chk(32'(b > a), 32'h1);
    chk((b - a) & 32'hf, 32'h0);
    rd(ADDR_STATUS, q);
    chk(32'(q[STAT_INWIN]), 32'h1);
    set_cmd(32'sh20, 0, 0, 0);
    tick(1);
    rd(ADDR_VEL_CMD, a);
    tick(3);
    rdc(ADDR_VEL_CMD, a);
    rd(ADDR_STATUS, q);
    chk(32'(q[STAT_INWIN]), 32'h0);
    wr(ADDR_POS_INT, 32'h0);
    // Settled random points; first one saturates the command sum and the velocity command
    for (int i = 0; i < 6; i++) begin
      foreach (v[k]) v[k] = $urandom_range(32'h7fff) - 32'h4000;
      kp = 16'($urandom_range(32'h100));
      kvp = 16'($urandom_range(32'h400, 32'h1));
      fx = 1'($urandom_range(1));
      if (i == 0) begin
        v[0] = 32'sh40000000;
        v[1] = 32'sh40000000;
        v[2] = '0;
        v[3] = '0;
        v[4] = '0;
        {kp, fx} = {16'hffff, 1'b0};
      end
      wr(ADDR_POS_PROP, 32'(kp));
      wr(ADDR_VEL_PROP, 32'(kvp));
      wr(ADDR_VEL_LEAD, $urandom_range(32'h100));
      wr(ADDR_ACCEL_LEAD, $urandom_range(32'hffff));
      wr(ADDR_CTRL, 32'(fx));
      set_cmd(v[0], v[1], v[2], v[3]);
      set_fb(v[4], v[5]);
      tick(4);
      e = sat(64'(v[0]) + 64'(v[1]) + 64'(v[2]) + 64'(v[3])
              - (fx ? 64'(v[5]) : 64'(v[4])));
      vc = mul(kp, e);
      rdc(ADDR_TRACK_ERR, e);
      rdc(ADDR_VEL_CMD, vc);
      rdc(ADDR_SPEED, 32'h0);
      rdc(ADDR_TORQUE, mul(kvp, vc));
      chk(applied_torque, mul(kvp, vc));
    end
    // Ramps: motor moves slowly, feedback taken from the external side
    wr(ADDR_POS_PROP, 32'h0);
    wr(ADDR_VEL_LEAD, 32'h100);
    wr(ADDR_ACCEL_LEAD, 32'h0);
    wr(ADDR_VEL_PROP, 32'h100);
    wr(ADDR_CTRL, 32'h1);
    set_fb(0, 32'sh77);
    {motor_rate, slow, ramp_on} <= {32'sd3, 1'b1, 1'b1};
    tick(4);
    rdc(ADDR_SPEED, 32'(3 * TC));
    rdc(ADDR_VEL_CMD, 32'(5 * TC));
    rdc(ADDR_TORQUE, 32'(2 * TC));
    wr(ADDR_VEL_LEAD, 32'h0);
    wr(ADDR_ACCEL_LEAD, 32'h100);
    ramp_a <= 32'sd1;
    tick(4);
    rdc(ADDR_VEL_CMD, 32'(TC * TC));
    {ramp_on, ramp_a, motor_rate, slow} <= '0;
    wr(ADDR_ACCEL_LEAD, 32'h0);
    // Manual tune with a live gain change
    set_cmd(0, 0, 0, 0);
    set_fb(0, 0);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_POS_PROP, 32'h100);
    tick(4);
    rdc(ADDR_TRACK_ERR, RST_TUNE_STEP);
    wr(ADDR_POS_PROP, 32'h200);
    tick(4);
    rdc(ADDR_VEL_CMD, 2 * RST_TUNE_STEP);
    // Velocity integrator on, then cleared by a zero gain
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_POS_PROP, 32'h100);
    wr(ADDR_VEL_INT, 32'h100);
    set_cmd(32'sh8, 0, 0, 0);
    tick(4);
    rd(ADDR_TORQUE, a);
    tick(2);
    rd(ADDR_TORQUE, b);
    chk(32'(b > a), 32'h1);
    chk((b - a) & 32'h7, 32'h0);
    wr(ADDR_VEL_INT, 32'h0);
    tick(4);
    rdc(ADDR_TORQUE, 32'h8);
    // Automatic tuning
    wr(ADDR_CTRL, 32'h4);
    tick(1);
    rd(ADDR_STATUS, q);
    chk(32'(q[STAT_BUSY]), 32'h1);
    j = 0;
    do begin
      tick(1);
      rd(ADDR_STATUS, q);
      j++;
    end while (q[STAT_DONE] !== 1'b1 && j < 200);
    chk(32'(q[STAT_DONE]), 32'h1);
    rdc(ADDR_POS_PROP, 32'(AUTO_POS_PROP));
    rdc(ADDR_POS_INT, 32'(AUTO_POS_INT));
    rdc(ADDR_VEL_LEAD, 32'(AUTO_VEL_LEAD));
    rdc(ADDR_ACCEL_LEAD, 32'(AUTO_ACCEL_LEAD));
    rdc(ADDR_VEL_PROP, 32'(AUTO_VEL_PROP));
    rdc(ADDR_VEL_INT, 32'(AUTO_VEL_INT));
    wr(ADDR_STATUS, 32'h2);
    rd(ADDR_STATUS, q);
    chk(32'(q[STAT_DONE]), 32'h0);
    final_report();
  end
endmodule // servo_position_velocity_loop_tb
`default_nettype wire
